/* File: lane_cfg_regs.sv */
// Lane 1..3 control and enable register bank of a four-lane redriver.
// Assumes a serial protocol engine delivers decoded address/data strobes.
`timescale 1ns/100ps
module lane_cfg_regs
   import lane_cfg_pkg::*;
(
   // Clock and reset
   input  wire logic                   i_ref_clk,
   input  wire logic                   i_rstn,
   // Register access from serial engine
   input  wire reg_req_t               i_req,
   input  wire logic [2:0]             i_addr_strap,
   input  wire logic                   i_config_source_select,
   output logic [6:0]                  o_target_addr,
   output logic [7:0]                  o_rdata,
   // Strap-pin fallback, one value shared by all lanes
   input  wire lane_control_t          i_strap_control,
   // Analog lane controls
   output lane_control_t [NUM_LANES-1:0] o_lane_control,
   output lane_enables_t [NUM_LANES-1:0] o_lane_enables
);
   bank_state_t state_reg;
   bank_state_t state_next;

   // Write data seen as each register's fields, for the checks below
   lane_control_t wdata_as_ctl;
   lane_enables_t wdata_as_ena;
   assign wdata_as_ctl = lane_control_t'(i_req.wdata);
   assign wdata_as_ena = lane_enables_t'(i_req.wdata);

   // Address of each lane's pair, indexed by lane
   localparam logic [7:0] CTL_ADDR [NUM_LANES] =
      '{ADDR_LANE1_CONTROL, ADDR_LANE2_CONTROL, ADDR_LANE3_CONTROL};
   localparam logic [7:0] ENA_ADDR [NUM_LANES] =
      '{ADDR_LANE1_ENABLES, ADDR_LANE2_ENABLES, ADDR_LANE3_ENABLES};

   // Next state: writes update masked bits, read data follows address
   always_comb begin
      state_next       = state_reg;
      state_next.rdata = READ_ZERO; // Gaps read zero
      for (int i = 0; i < NUM_LANES; i++) begin
         if (i_req.addr == CTL_ADDR[i]) begin
            state_next.rdata = state_reg.control[i];
            if (i_req.wr_en) begin
               state_next.control[i] = lane_control_t'(i_req.wdata & CONTROL_WR_MASK);
               state_next.rdata      = i_req.wdata;
            end
         end
         if (i_req.addr == ENA_ADDR[i]) begin
            state_next.rdata = state_reg.enables[i] & ENABLES_WR_MASK;
            if (i_req.wr_en) begin
               // Upper bits never stored, so they stay zero
               state_next.enables[i] = lane_enables_t'(i_req.wdata & ENABLES_WR_MASK);
               state_next.rdata      = i_req.wdata & ENABLES_WR_MASK;
            end
         end
      end
      // Lane drive is registered from the next state, so a write reaches
      // the analog side on the same edge as the register itself.
      // Strap mode forces the enables clear so no stage can stay off
      // by a value left over from register mode.
      for (int i = 0; i < NUM_LANES; i++) begin
         if (i_config_source_select) begin
            state_next.lane_ctl[i] = i_strap_control;
            state_next.lane_ena[i] = lane_enables_t'(REG_RESET_VAL);
         end else begin
            state_next.lane_ctl[i] = state_next.control[i];
            state_next.lane_ena[i] = state_next.enables[i];
         end
      end
      // Straps sampled every cycle; valid from the first edge after reset
      state_next.target_addr = {TARGET_ADDR_HI, i_addr_strap};
   end

   // State register, cleared to zero by reset
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // Target address and lane drive come straight from flip-flops
   assign o_target_addr = state_reg.target_addr;
   assign o_rdata       = state_reg.rdata;

   // One copy of the lane drive per lane; fields keep their bit places
   // so step, gain and stage bits land on the analog side unchanged.
   generate
      for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
         assign o_lane_control[g] = state_reg.lane_ctl[g];
         assign o_lane_enables[g] = state_reg.lane_ena[g];
      end
   endgenerate

   // Checks
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);

   ctl_write_holds_a: assert property (
      i_req.wr_en && i_req.addr == ADDR_LANE1_CONTROL
      |=> state_reg.control[0] == $past(i_req.wdata))
      else $error("lane1 control write lost");
   ena_write_masked_a: assert property (
      i_req.wr_en && i_req.addr == ADDR_LANE3_ENABLES
      |=> state_reg.enables[2] == ($past(i_req.wdata) & ENABLES_WR_MASK))
      else $error("lane3 enable write wrong");
   ena_upper_zero_a: assert property (
      state_reg.enables[1].reserved_bit == '0)
      else $error("enable upper bits not zero");
   gap_reads_zero_a: assert property (
      i_req.addr == ADDR_GAP_LANE1_2 |=> o_rdata == READ_ZERO)
      else $error("gap address read nonzero");
   lane_follow_reg_a: assert property (
      !i_config_source_select |=> o_lane_control[1] == state_reg.control[1])
      else $error("lane2 control not from register");
   strap_mode_a: assert property (
      i_config_source_select |=> o_lane_control[2] == $past(i_strap_control))
      else $error("strap control not used");
   target_addr_a: assert property (
      1'b1 |=> o_target_addr[6:3] == TARGET_ADDR_HI
               && o_target_addr[2:0] == $past(i_addr_strap))
      else $error("target address wrong");
   readback_a: assert property (
      !i_req.wr_en && i_req.addr == ADDR_LANE2_CONTROL
      |=> o_rdata == $past(state_reg.control[1]))
      else $error("lane2 control readback wrong");
   reset_zero_a: assert property (
      $rose(i_rstn) |-> state_reg.control[0] == '0)
      else $error("control not zero after reset");

   // Per-lane checks: each non-reserved field of a register-mode write shows on its own
   // lane pins one edge later, read data tracks the register, and a write
   // to any other address leaves the lane's registers alone.
   generate
      for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane_chk
         // Control fields
         step_field_a: assert property (
            i_req.wr_en && i_req.addr == CTL_ADDR[g] && !i_config_source_select
            |=> o_lane_control[g].equalizer_step == $past(wdata_as_ctl.equalizer_step))
            else $error("equalizer step not on lane pins");
         tx_gain_field_a: assert property (
            i_req.wr_en && i_req.addr == CTL_ADDR[g] && !i_config_source_select
            |=> o_lane_control[g].output_dc_boost_ctl == $past(wdata_as_ctl.output_dc_boost_ctl))
            else $error("output gain bit not on lane pins");
         eq_gain_field_a: assert property (
            i_req.wr_en && i_req.addr == CTL_ADDR[g] && !i_config_source_select
            |=> o_lane_control[g].equalizer_dc_level == $past(wdata_as_ctl.equalizer_dc_level))
            else $error("equalizer gain bit not on lane pins");
         rx_gain_field_a: assert property (
            i_req.wr_en && i_req.addr == CTL_ADDR[g] && !i_config_source_select
            |=> o_lane_control[g].rx_gain_code == $past(wdata_as_ctl.rx_gain_code))
            else $error("receiver gain code not on lane pins");

         // Enable fields
         peaking_field_a: assert property (
            i_req.wr_en && i_req.addr == ENA_ADDR[g] && !i_config_source_select
            |=> o_lane_enables[g].driver_peaking_on == $past(wdata_as_ena.driver_peaking_on))
            else $error("peaking bit not on lane pins");
         eq_off_field_a: assert property (
            i_req.wr_en && i_req.addr == ENA_ADDR[g] && !i_config_source_select
            |=> o_lane_enables[g].equalizer_stage_off == $past(wdata_as_ena.equalizer_stage_off))
            else $error("equalizer off bit not on lane pins");
         drv_off_field_a: assert property (
            i_req.wr_en && i_req.addr == ENA_ADDR[g] && !i_config_source_select
            |=> o_lane_enables[g].driver_stage_off == $past(wdata_as_ena.driver_stage_off))
            else $error("driver off bit not on lane pins");
         ena_pins_upper_a: assert property (
            o_lane_enables[g].reserved_bit == '0)
            else $error("enable pins upper bits not zero");

         // Read path: echo in the write cycle, register value otherwise
         ctl_echo_a: assert property (
            i_req.wr_en && i_req.addr == CTL_ADDR[g] |=> o_rdata == $past(i_req.wdata))
            else $error("control write not echoed");
         ena_echo_a: assert property (
            i_req.wr_en && i_req.addr == ENA_ADDR[g]
            |=> o_rdata == ($past(i_req.wdata) & ENABLES_WR_MASK))
            else $error("enable write echo not masked");
         ctl_read_a: assert property (
            !i_req.wr_en && i_req.addr == CTL_ADDR[g]
            |=> o_rdata == $past(state_reg.control[g]))
            else $error("control read from wrong register");
         ena_read_a: assert property (
            !i_req.wr_en && i_req.addr == ENA_ADDR[g]
            |=> o_rdata == $past(state_reg.enables[g]))
            else $error("enable read from wrong register");

         // Mode and stray writes
         strap_ena_clear_a: assert property (
            i_config_source_select |=> o_lane_enables[g] == '0)
            else $error("strap mode left a stage off");
         ctl_kept_a: assert property (
            !(i_req.wr_en && i_req.addr == CTL_ADDR[g]) |=> $stable(state_reg.control[g]))
            else $error("control changed without its write");
         ena_kept_a: assert property (
            !(i_req.wr_en && i_req.addr == ENA_ADDR[g]) |=> $stable(state_reg.enables[g]))
            else $error("enables changed without their write");
      end
   endgenerate

   cover_ctl_wr: cover property (i_req.wr_en && i_req.addr == ADDR_LANE2_CONTROL);
   cover_ena_wr: cover property (i_req.wr_en && i_req.addr == ADDR_LANE1_ENABLES);
   cover_gap_wr: cover property (i_req.wr_en && i_req.addr == ADDR_GAP_LANE2_3);
   cover_strap:  cover property (i_config_source_select);
   cover_ena_rd: cover property (!i_req.wr_en && i_req.addr == ADDR_LANE3_ENABLES);
endmodule : lane_cfg_regs

/* File: lane_cfg_pkg.sv */
// Package for the redriver lane configuration register bank.
// Assumes 8-bit register addresses and 8-bit data from a serial engine.
package lane_cfg_pkg;
   // Register addresses
   localparam logic [7:0] ADDR_LANE1_CONTROL = 8'h05;
   localparam logic [7:0] ADDR_LANE1_ENABLES = 8'h06;
   localparam logic [7:0] ADDR_LANE2_CONTROL = 8'h08;
   localparam logic [7:0] ADDR_LANE2_ENABLES = 8'h09;
   localparam logic [7:0] ADDR_LANE3_CONTROL = 8'h0B;
   localparam logic [7:0] ADDR_LANE3_ENABLES = 8'h0C;
   // Unmapped holes between the lane pairs
   localparam logic [7:0] ADDR_GAP_LANE1_2   = 8'h07;
   localparam logic [7:0] ADDR_GAP_LANE2_3   = 8'h0A;
   // Reset values and writable masks
   localparam logic [7:0] REG_RESET_VAL      = 8'h00;
   localparam logic [7:0] ENABLES_WR_MASK    = 8'h07;
   localparam logic [7:0] CONTROL_WR_MASK    = 8'hFF;
   localparam logic [7:0] READ_ZERO          = 8'h00;
   // Serial target address: upper four bits fixed at zero
   localparam logic [3:0] TARGET_ADDR_HI     = 4'h0;
   localparam int         NUM_LANES          = 3;

   // Decoded control register of one lane
   typedef struct packed {
      logic       reserved_bit;
      logic [2:0] equalizer_step;
      logic       output_dc_boost_ctl;
      logic       equalizer_dc_level;
      logic [1:0] rx_gain_code;
   } lane_control_t;

   // Decoded enable register of one lane
   typedef struct packed {
      logic [4:0] reserved_bit;
      logic       driver_peaking_on;
      logic       equalizer_stage_off;
      logic       driver_stage_off;
   } lane_enables_t;

   // Register write / read request from the serial engine
   typedef struct packed {
      logic       wr_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   // All held state of the bank
   typedef struct packed {
      lane_control_t [NUM_LANES-1:0] control;
      lane_enables_t [NUM_LANES-1:0] enables;
      logic [7:0]                    rdata;
      lane_control_t [NUM_LANES-1:0] lane_ctl;
      lane_enables_t [NUM_LANES-1:0] lane_ena;
      logic [6:0]                    target_addr;
   } bank_state_t;
endpackage : lane_cfg_pkg

/* File: lane_host_model.sv */
// Host model: issues register writes and reads to the lane bank.
// Assumes it shares the bank clock; it drives requests on falling edges.
`timescale 1ns/100ps
module lane_host_model
   import lane_cfg_pkg::*;
(
   // Clock
   input  wire logic       i_ref_clk,
   // Request out, read data back
   output reg_req_t        o_req,
   input  wire logic [7:0] i_rdata
);
   initial o_req = '0;
   // One-cycle write strobe; data inverted after release so stale data never matches
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_ref_clk) o_req = '{wr_en: 1'b1, addr: a, wdata: d};
      @(negedge i_ref_clk) o_req = '{wr_en: 1'b0, addr: a, wdata: ~d};
   endtask : wr
   // Address held over one rising edge, answer taken at the next falling edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge i_ref_clk) o_req = '{wr_en: 1'b0, addr: a, wdata: 8'h00};
      @(negedge i_ref_clk) d = i_rdata;
   endtask : rd
endmodule : lane_host_model

/* File: redriver_lane_config_regs_test.sv */
// Self-checking bench for the lane configuration register bank.
// Assumes the bank's own assertions watch timing; this bench checks values.
`timescale 1ns/100ps
module redriver_lane_config_regs_test;
   import lane_cfg_pkg::*;
   logic                          i_ref_clk = 1'b0;
   logic                          i_rstn = 1'b0;
   logic                          i_sel = 1'b0;
   logic [2:0]                    i_strap = 3'h5;
   lane_control_t                 i_sc = 8'h00;
   reg_req_t                      req;
   logic [6:0]                    tgt;
   logic [7:0]                    rdata, d;
   lane_control_t [NUM_LANES-1:0] lc;
   lane_enables_t [NUM_LANES-1:0] le;
   int                            fail_count = 0, n_checks = 0;
   logic [7:0] ca [3] = '{ADDR_LANE1_CONTROL, ADDR_LANE2_CONTROL, ADDR_LANE3_CONTROL};
   logic [7:0] ea [3] = '{ADDR_LANE1_ENABLES, ADDR_LANE2_ENABLES, ADDR_LANE3_ENABLES};
   logic [7:0] cv [3] = '{8'hFF, 8'h75, 8'h0D}; // Bit 2 set, as hosts should
   always #5 i_ref_clk = ~i_ref_clk;
   lane_host_model host (.i_ref_clk(i_ref_clk), .o_req(req), .i_rdata(rdata));
   lane_cfg_regs dut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_req(req),
      .i_addr_strap(i_strap), .i_config_source_select(i_sel), .o_target_addr(tgt),
      .o_rdata(rdata), .i_strap_control(i_sc), .o_lane_control(lc), .o_lane_enables(le));
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : conclude
   // Every lane register reads zero out of reset
   task automatic t_reset;
      for (int i = 0; i < 3; i++) begin
         host.rd(ca[i], d);
         check("control reset", d, 8'h00);
         host.rd(ea[i], d);
         check("enables reset", d, 8'h00);
      end
   endtask : t_reset
   // Distinct values per lane catch aliased or swapped decodes
   task automatic t_control;
      for (int i = 0; i < 3; i++) host.wr(ca[i], cv[i]);
      for (int i = 0; i < 3; i++) begin
         check("lane control", lc[i], cv[i]);
         host.rd(ca[i], d);
         check("control read", d, cv[i]);
      end
   endtask : t_control
   // Upper enable bits must drop writes
   task automatic t_enables;
      for (int i = 0; i < 3; i++) begin
         host.wr(ea[i], 8'hFF);
         check("lane enables", le[i], 8'h07);
         host.rd(ea[i], d);
         check("enables read", d, 8'h07);
      end
   endtask : t_enables
   // Gap addresses hold nothing and leave lane 2 control undisturbed
   task automatic t_gap;
      host.wr(8'h07, 8'hFF);
      host.wr(8'h0A, 8'hFF);
      host.rd(8'h07, d);
      check("gap 07", d, 8'h00);
      host.rd(8'h0A, d);
      check("gap 0a", d, 8'h00);
      host.rd(ca[1], d);
      check("neighbour", d, cv[1]);
   endtask : t_gap
   // Strap source overrides registers; target address follows straps
   task automatic t_strap;
      @(negedge i_ref_clk);
      i_sc = 8'h5A;
      i_sel = 1'b1;
      i_strap = 3'h2;
      @(negedge i_ref_clk);
      check("strap control", lc[2], 8'h5A);
      check("strap enables", le[2], 8'h00);
      check("target addr", {1'b0, tgt}, 8'h02);
      i_sel = 1'b0;
      @(negedge i_ref_clk);
      check("register control", lc[2], cv[2]);
   endtask : t_strap
   // Reset in mid-run clears registers and lane drive alike
   task automatic t_mid_reset;
      @(negedge i_ref_clk) i_rstn = 1'b0;
      @(negedge i_ref_clk) i_rstn = 1'b1;
      check("lane control after reset", lc[0], 8'h00);
      check("lane enables after reset", le[1], 8'h00);
      host.rd(ca[2], d);
      check("control after reset", d, 8'h00);
   endtask : t_mid_reset
   initial begin
      repeat (3) @(negedge i_ref_clk);
      i_rstn = 1'b1;
      t_reset();
      t_control();
      t_enables();
      t_gap();
      t_strap();
      t_mid_reset();
      conclude();
   end
   // Whole run is under 100 cycles; 2000 is ample
   initial begin
      #20000;
      fail_count++;
      conclude();
   end
endmodule : redriver_lane_config_regs_test
